// file: rtl/pft_pkg.sv
// Constants, tables and carrier types for the protection fault timer bank.
// Assumes a 20 MHz system clock; all timer tables are held in microseconds.
package pft_pkg;
	// Clock and time base
	localparam int CLOCK_PERIOD_NS     = 50;
	localparam int TICK_NS             = 1000;
	localparam int US_TICK_CYCLES      = (TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int STEP1_UNIT_NS       = 25;
	localparam int STEP1_MAX_NS        = 25575;
	localparam int STEP1_MAX_CYCLES    = (STEP1_MAX_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int GATE_OFF_MAX_NS     = 1000;
	localparam int GATE_OFF_MAX_CYCLES = GATE_OFF_MAX_NS / CLOCK_PERIOD_NS;

	// Timer bank layout
	localparam int NUM_TIMERS = 10;
	localparam int LIM_W      = 27;
	localparam int T_COOL     = 0;
	localparam int T_RETRY_OK = 1;
	localparam int T_IN_UV    = 2;
	localparam int T_OV       = 3;
	localparam int T_FAST_OV  = 4;
	localparam int T_OUT_UV   = 5;
	localparam int T_WDOG     = 6;
	localparam int T_OC_DEG   = 7;
	localparam int T_OC_REG   = 8;
	localparam int T_SC       = 9;
	localparam logic [9:0] GATE_FAULT_MASK = 10'h3fc;

	// Register map
	localparam logic [7:0] ADDR_CFG_A  = 8'h00;
	localparam logic [7:0] ADDR_CFG_B  = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_INT_ST = 8'h0c;
	localparam logic [7:0] ADDR_INT_MK = 8'h10;
	localparam logic [31:0] CFG_A_RST  = 32'h0000_0000;
	localparam logic [31:0] CFG_B_RST  = 32'h0000_0000;
	localparam logic [11:0] INT_MK_RST = 12'h000;

	// Field positions, CFG_A
	localparam int FLD_COOL      = 0;
	localparam int FLD_RETRY_OK  = 3;
	localparam int FLD_IN_UV     = 6;
	localparam int FLD_OV        = 9;
	localparam int FLD_FAST_OV   = 12;
	localparam int FLD_OUT_UV    = 15;
	localparam int FLD_OC_DEG    = 18;
	localparam int FLD_OC_REG    = 21;
	localparam int FLD_SC        = 24;
	localparam int FLD_RMS       = 27;
	// Field positions, CFG_B
	localparam int FLD_STEP1     = 0;
	localparam int FLD_WDOG      = 10;
	// Status register
	localparam int ST_STEP1_BUSY = 10;
	// Interrupt bits beyond the timer expiries
	localparam int INT_W         = 12;
	localparam int INT_STEP1     = 10;
	localparam int INT_RMS       = 11;

	// RMS window: 16 samples times 8 to the power of the code
	localparam logic [13:0] RMS_BASE  = 14'h0010;
	localparam int          RMS_SHIFT = 3;

	// Duration tables in microseconds
	typedef logic [LIM_W-1:0] pft_lim_type;
	localparam pft_lim_type COOL_US [8] = '{27'd0, 27'd1000000, 27'd2000000, 27'd4000000,
		27'd8000000, 27'd16000000, 27'd32000000, 27'd64000000};
	localparam pft_lim_type RETRY_US [8] = '{27'd0, 27'd500000, 27'd1000000, 27'd2000000,
		27'd3000000, 27'd4000000, 27'd6000000, 27'd8000000};
	localparam pft_lim_type STD_US [8] = '{27'd0, 27'd1000, 27'd5000, 27'd10000,
		27'd50000, 27'd100000, 27'd500000, 27'd1000000};
	localparam pft_lim_type FAST_OV_US [8] = '{27'd0, 27'd10, 27'd20, 27'd50,
		27'd100, 27'd200, 27'd500, 27'd1000};
	localparam pft_lim_type OC_DEG_US [8] = '{27'd0, 27'd500, 27'd1000, 27'd2000,
		27'd4000, 27'd6100, 27'd8000, 27'd10000};
	localparam pft_lim_type SC_US [8] = '{27'd0, 27'd10, 27'd100, 27'd1000,
		27'd10000, 27'd100000, 27'd500000, 27'd1000000};
	localparam pft_lim_type WDOG_US [16] = '{27'd5000, 27'd10000, 27'd20000, 27'd50000,
		27'd100000, 27'd200000, 27'd500000, 27'd1000000, 27'd2000000, 27'd3000000,
		27'd4000000, 27'd5000000, 27'd7500000, 27'd10000000, 27'd12500000, 27'd15000000};

	// Monitored conditions; bit order matches the timer indices
	typedef struct packed {
		logic short_circuit;
		logic oc_soa_reg;
		logic oc_soa_viol;
		logic wdog_run;
		logic out_uv;
		logic fast_ovin;
		logic ov;
		logic in_uv;
		logic retry_ok;
		logic retry_pending;
	} pft_cond_type;
endpackage

// file: rtl/pft_tick_gen.sv
// Microsecond tick generator for the timer bank.
// Assumes a synchronised active-low reset and a shared clock enable.
`timescale 1ns/1ns
`default_nettype none
module pft_tick_gen #(
	parameter int TICK_CYCLES = pft_pkg::US_TICK_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic clock_en,
	output var  logic tick
);
	logic [15:0] div_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 16'h0000;
			tick    <= 1'b0;
		end else if (clock_en) begin
			tick <= (div_reg == 16'(TICK_CYCLES - 1));
			if (div_reg == 16'(TICK_CYCLES - 1))
				div_reg <= 16'h0000;
			else
				div_reg <= div_reg + 16'h0001;
		end
	end
endmodule // pft_tick_gen
`default_nettype wire

// file: rtl/pft_qual_timer.sv
// One qualification timer: counts ticks while its condition holds.
// Assumes the tick is a one-cycle pulse in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module pft_qual_timer (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic                     clock_en,
	input  wire logic                     tick,
	input  wire logic                     cond,
	input  wire pft_pkg::pft_lim_type     limit,
	output var  logic                     expired,
	output var  logic                     expire_pulse
);
	pft_pkg::pft_lim_type cnt_reg;
	logic                 done_next;

	// Tick phase is free running, so a wait may be up to one tick short
	assign done_next = cond && (cnt_reg >= limit);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			cnt_reg <= '0;
		else if (clock_en) begin
			if (!cond)
				cnt_reg <= '0;
			else if (tick && cnt_reg < limit)
				cnt_reg <= cnt_reg + 27'd1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			expired      <= 1'b0;
			expire_pulse <= 1'b0;
		end else if (clock_en) begin
			expired      <= done_next;
			expire_pulse <= done_next && !expired;
		end
	end

	AST_QUAL_RESTART: assert property (@(posedge clock) disable iff (!rst_n)
		clock_en && !cond |=> !expired && cnt_reg == '0)
		else $error("timer kept state after its condition cleared");
endmodule // pft_qual_timer
`default_nettype wire

// file: rtl/pft_top.sv
// Protection fault timer bank: qualification, deglitch, retry and gate timers.
// Assumes condition inputs are synchronous to clock and a one-cycle register port.
`timescale 1ns/1ns
`default_nettype none
module pft_top #(
	parameter int US_TICK_CYCLES = pft_pkg::US_TICK_CYCLES
) (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic                  clock_en,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output var  logic [31:0]           reg_rdata,
	input  wire pft_pkg::pft_cond_type cond_in,
	input  wire logic                  wdog_kick,
	input  wire logic                  step1_start,
	input  wire logic                  adc_sample,
	output var  logic [9:0]            timer_expired,
	output var  logic [9:0]            timer_expire_pulse,
	output var  logic                  gate_off_req,
	output var  logic                  step1_active,
	output var  logic                  step1_done,
	output var  logic                  rms_window_done,
	output logic                       irq
);
	logic                         rst_meta_reg;
	logic                         rst_n;
	logic                         us_tick;
	logic [31:0]                  cfg_a_reg;
	logic [31:0]                  cfg_b_reg;
	logic [pft_pkg::INT_W-1:0]    int_st_reg;
	logic [pft_pkg::INT_W-1:0]    int_mk_reg;
	logic [pft_pkg::INT_W-1:0]    int_evt;
	logic [9:0]                   cond_vec;
	logic [9:0]                   step1_cnt_reg;
	logic [13:0]                  rms_cnt_reg;
	logic [13:0]                  rms_len;
	logic [2:0]                   cool_sel;
	logic [2:0]                   retry_ok_sel;
	logic [2:0]                   in_uv_sel;
	logic [2:0]                   ov_sel;
	logic [2:0]                   fast_ov_sel;
	logic [2:0]                   out_uv_sel;
	logic [2:0]                   oc_deg_sel;
	logic [2:0]                   oc_reg_sel;
	logic [2:0]                   sc_sel;
	logic [1:0]                   rms_sel;
	logic [9:0]                   step1_units;
	logic [3:0]                   wdog_sel;
	pft_pkg::pft_lim_type         limit [pft_pkg::NUM_TIMERS];

	// 3-bit field extraction, shared by the nine CFG_A timer select fields
	function automatic logic [2:0] field3(input logic [31:0] word, input int pos);
		field3 = word[pos +: 3];
	endfunction

	// First-step length in clocks, rounded up so the step is never short
	function automatic logic [9:0] step1_cycles(input logic [9:0] units);
		logic [15:0] ns;
		ns = 16'(units) * 16'(pft_pkg::STEP1_UNIT_NS);
		step1_cycles = 10'((ns + 16'(pft_pkg::CLOCK_PERIOD_NS - 1)) / 16'(pft_pkg::CLOCK_PERIOD_NS));
	endfunction

	// Reset release through two flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	assign cool_sel     = field3(cfg_a_reg, pft_pkg::FLD_COOL);
	assign retry_ok_sel = field3(cfg_a_reg, pft_pkg::FLD_RETRY_OK);
	assign in_uv_sel    = field3(cfg_a_reg, pft_pkg::FLD_IN_UV);
	assign ov_sel       = field3(cfg_a_reg, pft_pkg::FLD_OV);
	assign fast_ov_sel  = field3(cfg_a_reg, pft_pkg::FLD_FAST_OV);
	assign out_uv_sel   = field3(cfg_a_reg, pft_pkg::FLD_OUT_UV);
	assign oc_deg_sel   = field3(cfg_a_reg, pft_pkg::FLD_OC_DEG);
	assign oc_reg_sel   = field3(cfg_a_reg, pft_pkg::FLD_OC_REG);
	assign sc_sel       = field3(cfg_a_reg, pft_pkg::FLD_SC);
	assign rms_sel      = cfg_a_reg[pft_pkg::FLD_RMS +: 2];
	assign step1_units  = cfg_b_reg[pft_pkg::FLD_STEP1 +: 10];
	assign wdog_sel     = cfg_b_reg[pft_pkg::FLD_WDOG +: 4];

	// Duration decode per timer
	always_comb begin
		limit[pft_pkg::T_COOL]     = pft_pkg::COOL_US[cool_sel];
		limit[pft_pkg::T_RETRY_OK] = pft_pkg::RETRY_US[retry_ok_sel];
		limit[pft_pkg::T_IN_UV]    = pft_pkg::STD_US[in_uv_sel];
		limit[pft_pkg::T_OV]       = pft_pkg::STD_US[ov_sel];
		limit[pft_pkg::T_FAST_OV]  = pft_pkg::FAST_OV_US[fast_ov_sel];
		limit[pft_pkg::T_OUT_UV]   = pft_pkg::STD_US[out_uv_sel];
		limit[pft_pkg::T_WDOG]     = pft_pkg::WDOG_US[wdog_sel];
		limit[pft_pkg::T_OC_DEG]   = pft_pkg::OC_DEG_US[oc_deg_sel];
		limit[pft_pkg::T_OC_REG]   = pft_pkg::STD_US[oc_reg_sel];
		limit[pft_pkg::T_SC]       = pft_pkg::SC_US[sc_sel];
	end

	// A kick drops the watchdog condition for a cycle, restarting its count
	always_comb begin
		cond_vec = cond_in;
		cond_vec[pft_pkg::T_WDOG] = cond_in.wdog_run && !wdog_kick;
	end

	pft_tick_gen #(
		.TICK_CYCLES (US_TICK_CYCLES)
	) u_tick (
		.clock    (clock),
		.rst_n    (rst_n),
		.clock_en (clock_en),
		.tick     (us_tick)
	);

	for (genvar i = 0; i < pft_pkg::NUM_TIMERS; i++) begin : g_timer
		pft_qual_timer u_timer (
			.clock        (clock),
			.rst_n        (rst_n),
			.clock_en     (clock_en),
			.tick         (us_tick),
			.cond         (cond_vec[i]),
			.limit        (limit[i]),
			.expired      (timer_expired[i]),
			.expire_pulse (timer_expire_pulse[i])
		);
	end

	// Registered so the request is clean; one clock is well inside 1 us
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			gate_off_req <= 1'b0;
		else if (clock_en)
			gate_off_req <= |(timer_expired & pft_pkg::GATE_FAULT_MASK);
	end

	// First step of the two-step gate turn-off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			step1_cnt_reg <= 10'h000;
			step1_active  <= 1'b0;
			step1_done    <= 1'b0;
		end else if (clock_en) begin
			step1_done <= 1'b0;
			if (step1_start && !step1_active) begin
				if (step1_cycles(step1_units) == 10'h000)
					step1_done <= 1'b1;
				else begin
					step1_active  <= 1'b1;
					step1_cnt_reg <= step1_cycles(step1_units) - 10'h001;
				end
			end else if (step1_active) begin
				if (step1_cnt_reg == 10'h000) begin
					step1_active <= 1'b0;
					step1_done   <= 1'b1;
				end else
					step1_cnt_reg <= step1_cnt_reg - 10'h001;
			end
		end
	end

	// RMS integration window counted in converter samples
	assign rms_len = pft_pkg::RMS_BASE << (pft_pkg::RMS_SHIFT * rms_sel);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rms_cnt_reg     <= 14'h0000;
			rms_window_done <= 1'b0;
		end else if (clock_en) begin
			rms_window_done <= 1'b0;
			if (adc_sample) begin
				if (rms_cnt_reg >= rms_len - 14'h0001) begin
					rms_cnt_reg     <= 14'h0000;
					rms_window_done <= 1'b1;
				end else
					rms_cnt_reg <= rms_cnt_reg + 14'h0001;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_a_reg <= pft_pkg::CFG_A_RST;
			cfg_b_reg <= pft_pkg::CFG_B_RST;
			int_mk_reg <= pft_pkg::INT_MK_RST;
		end else if (clock_en && reg_wr) begin
			case (reg_addr)
				pft_pkg::ADDR_CFG_A:  cfg_a_reg  <= {3'h0, reg_wdata[28:0]};
				pft_pkg::ADDR_CFG_B:  cfg_b_reg  <= {18'h00000, reg_wdata[13:0]};
				pft_pkg::ADDR_INT_MK: int_mk_reg <= reg_wdata[pft_pkg::INT_W-1:0];
				default: ;
			endcase
		end
	end

	// Sticky events; a new event beats a write-one-to-clear in the same cycle
	assign int_evt = {rms_window_done, step1_done, timer_expire_pulse};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			int_st_reg <= '0;
		else if (clock_en) begin
			if (reg_wr && reg_addr == pft_pkg::ADDR_INT_ST)
				int_st_reg <= (int_st_reg & ~reg_wdata[pft_pkg::INT_W-1:0]) | int_evt;
			else
				int_st_reg <= int_st_reg | int_evt;
		end
	end

	assign irq = |(int_st_reg & int_mk_reg);

	// Read data stands one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (clock_en) begin
			if (reg_rd) begin
				case (reg_addr)
					pft_pkg::ADDR_CFG_A:  reg_rdata <= cfg_a_reg;
					pft_pkg::ADDR_CFG_B:  reg_rdata <= cfg_b_reg;
					pft_pkg::ADDR_STATUS: reg_rdata <= {21'h000000, step1_active, timer_expired};
					pft_pkg::ADDR_INT_ST: reg_rdata <= {20'h00000, int_st_reg};
					pft_pkg::ADDR_INT_MK: reg_rdata <= {20'h00000, int_mk_reg};
					default:              reg_rdata <= 32'h0000_0000;
				endcase
			end else
				reg_rdata <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_COOL_64S: assert property (cool_sel == 3'h7 |-> limit[pft_pkg::T_COOL] == 27'd64000000)
		else $error("cool-down code 7 not 64 s");
	AST_RETRY_HALF: assert property (retry_ok_sel == 3'h1 |-> limit[pft_pkg::T_RETRY_OK] == 27'd500000)
		else $error("retry-ok code 1 not 0.5 s");
	AST_STEP1_BOUND: assert property (step1_active |-> step1_cnt_reg < 10'd512)
		else $error("first step exceeds 25575 ns");
	AST_STEP1_END: assert property (clock_en && step1_active && step1_cnt_reg == 10'h000 |=> step1_done && !step1_active)
		else $error("first step did not end on count");
	AST_UV_5MS: assert property (in_uv_sel == 3'h2 |-> limit[pft_pkg::T_IN_UV] == 27'd5000)
		else $error("input undervoltage code 2 not 5 ms");
	AST_FAST_OV: assert property (fast_ov_sel == 3'h1 |-> limit[pft_pkg::T_FAST_OV] == 27'd10)
		else $error("fast overvoltage code 1 not 10 us");
	AST_WDOG_RANGE: assert property (limit[pft_pkg::T_WDOG] >= 27'd5000 && limit[pft_pkg::T_WDOG] <= 27'd15000000)
		else $error("watchdog timeout out of range");
	AST_OC_DEG: assert property (oc_deg_sel == 3'h5 |-> limit[pft_pkg::T_OC_DEG] == 27'd6100)
		else $error("overcurrent deglitch code 5 not 6.1 ms");
	AST_RMS_WIN: assert property (clock_en && adc_sample && rms_cnt_reg == rms_len - 14'h0001 |=> rms_window_done)
		else $error("RMS window end missed");
	AST_SC_10US: assert property (sc_sel == 3'h1 |-> limit[pft_pkg::T_SC] == 27'd10)
		else $error("short-circuit code 1 not 10 us");
	AST_GATE_OFF: assert property (clock_en && |(timer_expired & pft_pkg::GATE_FAULT_MASK) |=> gate_off_req)
		else $error("gate turn-off late after expiry");
	AST_NO_EARLY: assert property ($rose(timer_expired[pft_pkg::T_OV]) |-> $past(cond_in.ov))
		else $error("overvoltage fault without condition");
	AST_OV_1MS: assert property (ov_sel == 3'h1 |-> limit[pft_pkg::T_OV] == 27'd1000)
		else $error("overvoltage code 1 not 1 ms");
	AST_OUT_UV_10MS: assert property (out_uv_sel == 3'h3 |-> limit[pft_pkg::T_OUT_UV] == 27'd10000)
		else $error("output undervoltage code 3 not 10 ms");
	AST_OC_REG_1MS: assert property (oc_reg_sel == 3'h1 |-> limit[pft_pkg::T_OC_REG] == 27'd1000)
		else $error("overcurrent regulation code 1 not 1 ms");
	AST_RMS_128: assert property (rms_sel == 2'h1 |-> rms_len == 14'h0080)
		else $error("RMS code 1 not 128 samples");
	AST_STEP1_HOLD: assert property (
		clock_en && step1_active && step1_cnt_reg != 10'h000 |=> step1_active && !step1_done)
		else $error("first step ended early");
	AST_STEP1_ZERO: assert property (
		clock_en && step1_start && !step1_active && step1_units == 10'h000 |=> step1_done && !step1_active)
		else $error("zero first step not immediate");
	AST_PULSE_ONE: assert property (
		clock_en && timer_expire_pulse[pft_pkg::T_FAST_OV] |=> !timer_expire_pulse[pft_pkg::T_FAST_OV])
		else $error("expiry pulse longer than one cycle");
	AST_KICK_RESTART: assert property (clock_en && wdog_kick |=> !timer_expired[pft_pkg::T_WDOG])
		else $error("watchdog expiry survived a kick");
	AST_GATE_QUIET: assert property (
		clock_en && (timer_expired & pft_pkg::GATE_FAULT_MASK) == 10'h000 |=> !gate_off_req)
		else $error("gate turn-off without fault expiry");

	COV_OV_EXPIRE: cover property ($rose(timer_expired[pft_pkg::T_OV]));
	COV_STEP1: cover property (step1_done);
	COV_RMS: cover property (rms_window_done);
	COV_IRQ: cover property ($rose(irq));
	COV_WDOG_KICK: cover property (clock_en && wdog_kick);
endmodule // pft_top
`default_nettype wire

// file: tb/pft_fault_model.sv
// Far-side model of the timer bank: fault comparators and the converter sample strobe.
// Assumes the bench hands it comparator requests as levels on the bench clock.
`timescale 1ns/1ns
`default_nettype none
module pft_fault_model #(
	parameter int SAMPLE_SPAN = 4
) (
	input  wire logic                  clock,
	input  wire logic [9:0]            req,
	input  wire logic                  sample_en,
	output var  pft_pkg::pft_cond_type cond,
	output var  logic                  adc_sample
);
	// Outputs settle at the first edge, long before reset ends
	int span_cnt = 0;

	// Comparators resolve on the next edge, so a request lands one cycle late
	always @(posedge clock) begin
		cond <= pft_pkg::pft_cond_type'(req);
	end

	// Real sample rate is far slower; shortened so window tests stay brief
	always @(posedge clock) begin
		if (!sample_en) begin
			span_cnt   <= 0;
			adc_sample <= 1'b0;
		end else begin
			span_cnt   <= (span_cnt == SAMPLE_SPAN - 1) ? 0 : span_cnt + 1;
			adc_sample <= (span_cnt == SAMPLE_SPAN - 1);
		end
	end
endmodule // pft_fault_model
`default_nettype wire

// file: tb/tb_protection_fault_timers.sv
// Self-checking bench for the protection fault timer bank.
// Assumes one timer tick per clock so every duration in us equals that many cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_protection_fault_timers;
	localparam int TICK     = 1;
	localparam int SPAN     = 4;
	localparam int LIMIT    = 90000;
	localparam int STD [8]  = '{0, 1000, 5000, 10000, 50000, 100000, 500000, 1000000};
	localparam int FAST [8] = '{0, 10, 20, 50, 100, 200, 500, 1000};
	localparam int OCD [8]  = '{0, 500, 1000, 2000, 4000, 6100, 8000, 10000};
	localparam int SCT [8]  = '{0, 10, 100, 1000, 10000, 100000, 500000, 1000000};
	localparam int WDG [2]  = '{5000, 10000};

	logic                  clock, reset_n, clock_en, reg_wr, reg_rd;
	logic                  wdog_kick, step1_start, sample_en, adc_sample;
	logic                  gate_off_req, step1_active, step1_done, rms_window_done, irq;
	logic [7:0]            reg_addr;
	logic [31:0]           reg_wdata, reg_rdata, v;
	logic [9:0]            req, timer_expired, timer_expire_pulse;
	logic [9:0]            exp_prev = '0;
	logic [9:0]            cond_prev = '0;
	pft_pkg::pft_cond_type cond_in;
	int                    num_errors, num_checks, seed, cyc, rms_last, rms_int, rms_cnt;
	int                    rise [10];
	int                    lat [10];

	pft_top #(.US_TICK_CYCLES(TICK)) dut (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cond_in(cond_in), .wdog_kick(wdog_kick), .step1_start(step1_start), .adc_sample(adc_sample),
		.timer_expired(timer_expired), .timer_expire_pulse(timer_expire_pulse), .gate_off_req(gate_off_req),
		.step1_active(step1_active), .step1_done(step1_done), .rms_window_done(rms_window_done), .irq(irq));
	pft_fault_model #(.SAMPLE_SPAN(SPAN)) u_far (.clock(clock), .req(req), .sample_en(sample_en),
		.cond(cond_in), .adc_sample(adc_sample));

	task automatic final_report();
		if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_rng(input string name, input int lo, input int hi, input int got);
		num_checks++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(name, exp, reg_rdata);
	endtask

	// Kick mid-count shifts the expected expiry by the kick offset
	task automatic run_timer(input int fld, input int t, input int code, input int us, input int kick);
		int n;
		int k0;
		int k1;
		n  = 0;
		k0 = (kick > 0) ? kick - 2 : 0;
		k1 = (kick > 0) ? kick + 2 : 0;
		if (t == pft_pkg::T_WDOG) wr(pft_pkg::ADDR_CFG_B, 32'(code) << fld);
		else wr(pft_pkg::ADDR_CFG_A, 32'(code) << fld);
		req[t] <= 1'b1;
		while (timer_expired[t] !== 1'b1 && n < us * TICK + kick + 20) begin
			@(posedge clock);
			wdog_kick <= (kick > 0 && n == kick);
			n++;
			#1;
		end
		// The monitor logs the latency one edge after the expiry shows
		@(posedge clock);
		#1;
		if (us == 0) chk_rng("zero timer latency", 1, 1, lat[t]);
		else chk_rng("timer latency", (us - 1) * TICK + k0, us * TICK + 2 + k1, lat[t]);
		rchk("status", pft_pkg::ADDR_STATUS, 32'h1 << t);
		req[t] <= 1'b0;
		repeat (3) @(posedge clock);
		#1 chk("expired cleared", 32'h0, {22'h0, timer_expired});
	endtask

	task automatic run_step(input logic [9:0] units);
		int n;
		int c;
		c = (int'(units) * 25 + 49) / 50;
		wr(pft_pkg::ADDR_CFG_B, {22'h0, units});
		@(posedge clock);
		step1_start <= 1'b1;
		@(posedge clock);
		step1_start <= 1'b0;
		#1 n = 0;
		while (step1_active === 1'b1 && n < 600) begin
			n++;
			@(posedge clock);
			#1;
		end
		chk("step1 cycles", c, n);
		chk("step1_done", 32'h1, {31'h0, step1_done});
	endtask

	task automatic run_rms(input int code);
		int n;
		wr(pft_pkg::ADDR_CFG_A, 32'(code) << pft_pkg::FLD_RMS);
		sample_en <= 1'b1;
		// The first interval is timed from zero, so the second one is judged
		n = rms_cnt + 2;
		while (rms_cnt < n && cyc < LIMIT) @(posedge clock);
		chk("rms interval", 16 * (8 ** code) * SPAN, rms_int);
	endtask

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Event monitor: latencies, pulse shape and gate request follow-up
	always @(posedge clock) begin
		cyc++;
		if (reset_n === 1'b1) begin
			chk("gate_off_req", {31'h0, |exp_prev[9:2]}, {31'h0, gate_off_req});
			chk("expire_pulse", {22'h0, timer_expired & ~exp_prev}, {22'h0, timer_expire_pulse});
			for (int i = 0; i < 10; i++) begin
				if (cond_in[i] === 1'b1 && cond_prev[i] === 1'b0) rise[i] = cyc;
				if (timer_expired[i] === 1'b1 && exp_prev[i] === 1'b0) lat[i] = cyc - rise[i];
			end
			if (rms_window_done === 1'b1) begin
				rms_int  = cyc - rms_last;
				rms_last = cyc;
				rms_cnt++;
			end
		end
		exp_prev  = timer_expired;
		cond_prev = cond_in;
		if (cyc >= LIMIT) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		reset_n     = 1'b0;
		clock_en    = 1'b1;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		reg_addr    = 8'h00;
		reg_wdata   = 32'h0;
		wdog_kick   = 1'b0;
		step1_start = 1'b0;
		sample_en   = 1'b0;
		req         = 10'h000;
		seed        = 22710;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		// Reset values, CFG_A/CFG_B write-back and read-only status, then the unmapped word at 0x14
		for (int a = 0; a < 6; a++) rchk("reset value", 8'(a * 4), 32'h0);
		v = $random(seed);
		wr(pft_pkg::ADDR_CFG_A, v);
		rchk("cfg_a", pft_pkg::ADDR_CFG_A, v & 32'h1fff_ffff);
		wr(pft_pkg::ADDR_CFG_B, v);
		rchk("cfg_b", pft_pkg::ADDR_CFG_B, v & 32'h0000_3fff);
		wr(pft_pkg::ADDR_STATUS, v);
		rchk("status read only", pft_pkg::ADDR_STATUS, 32'h0);
		wr(8'h14, v);
		rchk("unmapped", 8'h14, 32'h0);
		for (int c = 0; c < 8; c++) run_timer(pft_pkg::FLD_FAST_OV, pft_pkg::T_FAST_OV, c, FAST[c], 0);
		for (int c = 0; c < 4; c++) run_timer(pft_pkg::FLD_SC, pft_pkg::T_SC, c, SCT[c], 0);
		for (int c = 0; c < 6; c++) run_timer(pft_pkg::FLD_OC_DEG, pft_pkg::T_OC_DEG, c, OCD[c], 0);
		run_timer(pft_pkg::FLD_COOL, pft_pkg::T_COOL, 0, 0, 0);
		run_timer(pft_pkg::FLD_RETRY_OK, pft_pkg::T_RETRY_OK, 0, 0, 0);
		run_timer(pft_pkg::FLD_IN_UV, pft_pkg::T_IN_UV, 2, STD[2], 0);
		run_timer(pft_pkg::FLD_OV, pft_pkg::T_OV, 1, STD[1], 0);
		run_timer(pft_pkg::FLD_OUT_UV, pft_pkg::T_OUT_UV, 3, STD[3], 0);
		run_timer(pft_pkg::FLD_OC_REG, pft_pkg::T_OC_REG, 1, STD[1], 0);
		for (int c = 0; c < 2; c++) run_timer(pft_pkg::FLD_WDOG, pft_pkg::T_WDOG, c, WDG[c], 0);
		run_timer(pft_pkg::FLD_WDOG, pft_pkg::T_WDOG, 0, WDG[0], 3000);
		// One-cycle dropout mid-count must restart the count
		wr(pft_pkg::ADDR_CFG_A, 32'd3 << pft_pkg::FLD_FAST_OV);
		req[pft_pkg::T_FAST_OV] <= 1'b1;
		repeat (30) @(posedge clock);
		req[pft_pkg::T_FAST_OV] <= 1'b0;
		@(posedge clock);
		req[pft_pkg::T_FAST_OV] <= 1'b1;
		repeat (FAST[3] + 10) @(posedge clock);
		chk_rng("restart latency", FAST[3] - 1, FAST[3] + 2, lat[pft_pkg::T_FAST_OV]);
		req <= 10'h000;
		// Interrupt raised by an expiry, masked, then cleared
		wr(pft_pkg::ADDR_INT_ST, 32'h0000_0fff);
		wr(pft_pkg::ADDR_INT_MK, 32'h0000_0010);
		run_timer(pft_pkg::FLD_FAST_OV, pft_pkg::T_FAST_OV, 0, 0, 0);
		rchk("int_st", pft_pkg::ADDR_INT_ST, 32'h0000_0010);
		chk("irq", 32'h1, {31'h0, irq});
		wr(pft_pkg::ADDR_INT_MK, 32'h0);
		#1 chk("irq masked", 32'h0, {31'h0, irq});
		wr(pft_pkg::ADDR_INT_MK, 32'h0000_0010);
		wr(pft_pkg::ADDR_INT_ST, 32'h0000_0010);
		#1 chk("irq cleared", 32'h0, {31'h0, irq});
		rchk("int_st cleared", pft_pkg::ADDR_INT_ST, 32'h0);
		run_step(10'h000);
		run_step(10'h3ff);
		run_step(10'($random(seed)));
		run_rms(0);
		run_rms(1);
		run_rms(2);
		final_report();
	end
endmodule // tb_protection_fault_timers
`default_nettype wire
